//--- inc/asrp_pkg.sv
`default_nettype none
package asrp_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;

  // clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 25000;

  // slowest grade figures, in ns
  localparam int unsigned ACCESS_NS     = 35;
  localparam int unsigned OE_ACCESS_NS  = 15;
  localparam int unsigned HOLD_NS       = 5;
  localparam int unsigned SETUP_NS      = 12;
  localparam int unsigned FLOAT_NS      = 8;
  localparam int unsigned STROBE_NS     = 20;
  localparam int unsigned ADDR_SETUP_NS = 0;

  // least times round up to whole cycles, at least one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned READ_CYC   = ns_to_cyc(ACCESS_NS);
  localparam int unsigned FLOAT_CYC  = ns_to_cyc(FLOAT_NS);
  localparam int unsigned SETUP_CYC  = ns_to_cyc(SETUP_NS);
  localparam int unsigned STROBE_CYC = ns_to_cyc(STROBE_NS);
  localparam int unsigned ASU_CYC    = ns_to_cyc(ADDR_SETUP_NS);
  localparam int unsigned WRITE_CYC  = (STROBE_CYC > FLOAT_CYC + SETUP_CYC) ?
                                       STROBE_CYC : FLOAT_CYC + SETUP_CYC;
  localparam int unsigned CNT_W      = 4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_READ  = 4'h2,
    ST_WRITE = 4'h4,
    ST_END   = 4'h8
  } asrp_state_e;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrp_req_s;

  typedef struct packed {
    logic              select_active_low_n;
    logic              select_active_high;
    logic              out_en_n;
    logic              strobe_n;
    logic [ADDR_W-1:0] addr;
  } asrp_pins_s;

endpackage
`default_nettype wire

//--- logic/asrp_host.sv
// What this block does
// - a write opens by taking both selects active and the strobe low in one cycle.
// - the write ends when the strobe rises, which this host does before either select moves.
// - write data is set up a cycle before the window, driven from the edge that opens it and held through the terminating rise.
// - the host drives data pins only while output enable is high during writes.
// - the write window lasts at least the strobe-to-float delay plus data set-up.
// - the address is stable before the window opens and held until after it closes.
`timescale 1ns/1ps
`default_nettype none
module asrp_host
  import asrp_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire asrp_req_s         req_i,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_data_o,
  output asrp_pins_s             pins_o,
  input  wire logic [DATA_W-1:0] data_pins_i,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe_o
);

  // ********************************
  // sequencing
  // ********************************
  asrp_state_e      state_q;
  logic [CNT_W-1:0] cnt_q;

  assign req_ready_o = (state_q == ST_IDLE);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid_i) begin
            state_q <= req_i.write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(READ_CYC)) begin
            state_q <= ST_END;
          end
        end
        ST_WRITE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WRITE_CYC - 1)) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // address and write data launch with the take, a full cycle ahead of the window
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o.addr <= '0;
      data_pins_o <= '0;
    end else if (req_valid_i && req_ready_o) begin
      pins_o.addr <= req_i.addr;
      data_pins_o <= req_i.wdata;
    end
  end

  // ********************************
  // pin drive
  // ********************************
  // selects stay active in ST_END so the strobe alone terminates the write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o.select_active_low_n <= 1'b1;
      pins_o.select_active_high  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          pins_o.select_active_low_n <= 1'b1;
          pins_o.select_active_high  <= 1'b0;
        end
        ST_READ, ST_WRITE, ST_END: begin
          pins_o.select_active_low_n <= 1'b0;
          pins_o.select_active_high  <= 1'b1;
        end
      endcase
    end
  end

  // strobe low only in ST_WRITE: a read or an idle host can never alter the array
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o.strobe_n <= 1'b1;
    end else begin
      pins_o.strobe_n <= (state_q != ST_WRITE);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o.out_en_n <= 1'b1;
    end else begin
      pins_o.out_en_n <= (state_q != ST_READ);
    end
  end

  // drive outlives the strobe by one cycle, giving a full cycle of data hold after the terminating rise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_pins_oe_o <= 1'b0;
    end else if (state_q == ST_WRITE) begin
      data_pins_oe_o <= 1'b1;
    end else if (state_q != ST_END) begin
      data_pins_oe_o <= 1'b0;
    end
  end

  // ********************************
  // read capture
  // ********************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state_q == ST_READ && cnt_q == CNT_W'(READ_CYC)) begin
        rsp_valid_o <= 1'b1;
        rsp_data_o  <= data_pins_i;
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  sequence wr_open_s;
    $fell(pins_o.strobe_n) && !pins_o.select_active_low_n && pins_o.select_active_high;
  endsequence

  wr_start_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(pins_o.strobe_n) |-> !pins_o.select_active_low_n && pins_o.select_active_high)
    else $error("write opened without both selects active");

  wr_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(pins_o.strobe_n) |-> !pins_o.select_active_low_n && pins_o.select_active_high)
    else $error("select moved before strobe ended the write");

  wr_data_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(pins_o.strobe_n) |-> data_pins_oe_o && $stable(data_pins_o))
    else $error("write data not held at terminating edge");

  no_contend_a: assert property (@(posedge clock_i) disable iff (rst_i)
    data_pins_oe_o |-> pins_o.out_en_n)
    else $error("host drives data while output enabled");

  wr_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_open_s |-> !pins_o.strobe_n [*2])
    else $error("write window too short");

  addr_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.strobe_n |=> $stable(pins_o.addr))
    else $error("address moved during write window");

  rd_time_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rsp_valid_o |-> $past(!pins_o.out_en_n, 2) && $past(!pins_o.out_en_n, 1))
    else $error("read sampled too early");

  rd_nowr_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.out_en_n |-> pins_o.strobe_n)
    else $error("strobe low during read");

  sequence rd_open_s;
    $fell(pins_o.out_en_n) && !pins_o.select_active_low_n && pins_o.select_active_high;
  endsequence

  sequence wr_close_s;
    pins_o.strobe_n && !pins_o.select_active_low_n && pins_o.select_active_high
      && data_pins_oe_o;
  endsequence

  sequence wr_release_s;
    pins_o.select_active_low_n && !pins_o.select_active_high && !data_pins_oe_o;
  endsequence

  wr_flow_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_open_s |-> !pins_o.strobe_n [*2] ##1 wr_close_s ##1 wr_release_s)
    else $error("write not ended by the strobe before release");

  rd_flow_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_open_s |-> !pins_o.out_en_n [*3] ##0 rsp_valid_o ##1 pins_o.out_en_n)
    else $error("read not sampled after the full access time");

  rsp_pulse_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("read response held for more than one cycle");

  wr_asu_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_open_s |-> $stable(pins_o.addr))
    else $error("address changed as the write window opened");

  wr_drive_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.strobe_n |-> data_pins_oe_o ##1 $stable(data_pins_o))
    else $error("write data not driven through the window");

  rd_addr_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !pins_o.out_en_n |=> $stable(pins_o.addr))
    else $error("address moved while output enabled");

endmodule
`default_nettype wire

//--- bench/asrp_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_sram_model
  import asrp_pkg::*;
#(
  parameter int LAT_NS = 30
)
(
  input  wire asrp_pins_s        pins_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  input  wire logic              host_oe_i,
  output logic [DATA_W-1:0]      wire_o,
  output logic                   fault_o
);
  // ********************************
  // storage, drivers and host checks
  // ********************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic [DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] wr_addr_q;
  logic              sel, drive, window;
  logic              bus_fault = 1'b0;
  logic              wr_fault  = 1'b0;
  bit                opened    = 1'b0;
  int unsigned       n_writes  = 0;
  realtime           t_open;
  assign sel    = !pins_i.select_active_low_n && pins_i.select_active_high;
  assign window = sel && !pins_i.strobe_n;
  assign drive  = sel && !pins_i.out_en_n && pins_i.strobe_n;
  // slow answer; old word stands until the delay runs out, a fresh write re-arms it
  always @(pins_i.addr or n_writes) begin
    rd_data <= #(LAT_NS) mem[pins_i.addr];
  end
  // released wire shows the inverse of its last value, not a stale copy
  assign wire_o = host_oe_i ? host_data_i : (drive ? rd_data : ~last_q);
  always @* if (host_oe_i || drive) last_q = host_oe_i ? host_data_i : rd_data;
  assign fault_o = bus_fault | wr_fault;
  always @* if (drive && host_oe_i) bus_fault = 1'b1;
  // the window leaving unknown at power-up is no write
  always @(posedge window) begin
    if (window === 1'b1) begin
      wr_addr_q = pins_i.addr;
      t_open    = $realtime;
      opened    = 1'b1;
    end
  end
  always @(negedge window) begin
    if (opened) begin
      if (pins_i.addr !== wr_addr_q) wr_fault = 1'b1;
      if ($realtime - t_open < FLOAT_NS + SETUP_NS) wr_fault = 1'b1;
      mem[wr_addr_q] = wire_o;
      opened   = 1'b0;
      n_writes = n_writes + 1;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_asrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_asrp_host
  import asrp_pkg::*;
;
  typedef struct packed {
    asrp_req_s         req;
    logic [DATA_W-1:0] exp;
  } asrp_row_s;
  logic              clock_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              req_valid_i = 1'b0;
  asrp_req_s         req_i = '0;
  logic              req_ready_o, rsp_valid_o, data_pins_oe_o, fault;
  logic [DATA_W-1:0] rsp_data_o, data_pins_o, wire_v, got;
  asrp_pins_s        pins_o;
  int                n_mismatch = 0;
  int                checks = 0;
  asrp_row_s         rows [6] = '{
    '{'{1'b1, 13'h0000, 8'ha5}, 8'h00}, '{'{1'b1, 13'h1fff, 8'h5a}, 8'h00},
    '{'{1'b0, 13'h0000, 8'h00}, 8'ha5}, '{'{1'b0, 13'h1fff, 8'h00}, 8'h5a},
    '{'{1'b1, 13'h0000, 8'h3c}, 8'h00}, '{'{1'b0, 13'h0000, 8'h00}, 8'h3c}};
  asrp_host uut (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .pins_o(pins_o), .data_pins_i(wire_v),
    .data_pins_o(data_pins_o), .data_pins_oe_o(data_pins_oe_o));
  asrp_sram_model #(.LAT_NS(30)) sram (.pins_i(pins_o), .host_data_i(data_pins_o),
    .host_oe_i(data_pins_oe_o), .wire_o(wire_v), .fault_o(fault));
  // **************
  // shared tasks
  // **************
  initial forever #12.5 clock_i = ~clock_i;
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_req(input asrp_req_s r);
    int i;
    for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(posedge clock_i) #1;
    check({7'h00, req_ready_o}, 8'h01);
    req_i = r;
    req_valid_i = 1'b1;
    @(posedge clock_i) #1;
    req_valid_i = 1'b0;
    check({7'h00, req_ready_o}, 8'h00);
    got = 8'h00;
    for (i = 0; i < 20 && !r.write; i++) begin
      @(posedge clock_i) #1;
      if (rsp_valid_o === 1'b1) begin
        got = rsp_data_o;
        break;
      end
    end
    @(posedge clock_i) #1;
    if (!r.write) check({7'h00, rsp_valid_o}, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // **************
  // tests
  // **************
  initial begin
    #(25 * 3000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    foreach (rows[k]) begin
      do_req(rows[k].req);
      if (!rows[k].req.write) check(got, rows[k].exp);
    end
    $display("table test done");
    do_req('{1'b1, 13'h0aaa, 8'hff});
    do_req('{1'b1, 13'h0aab, 8'h00});
    do_req('{1'b0, 13'h0aaa, 8'h00});
    check(got, 8'hff);
    $display("back to back test done");
    rst_i = 1'b1;
    #2 check({3'h0, pins_o.select_active_low_n, pins_o.select_active_high,
      pins_o.out_en_n, pins_o.strobe_n, data_pins_oe_o}, 8'h16);
    repeat (5) @(posedge clock_i);
    #1 rst_i = 1'b0;
    do_req('{1'b0, 13'h1fff, 8'h00});
    check(got, 8'h5a);
    check({7'h00, fault}, 8'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
